// ===== core/fan_loop_pkg.sv
// constants, field layouts and carrier types for the fan loop register bank
// assumes a single 25 MHz clock domain shared with the management bus slave
// What this block does
// - local start temperature sits in bits 7:3, 4 degree steps, 0 to 124, 32 after reset.
// - remote start temperature sits in bits 7:3, 4 degree steps, 48 (code 01100) after reset.
// - local span bits 2:0 decode 000=5, 001=10 (reset), 010=20, 011=40, 100=80 degrees.
// - remote span uses the same five doubling codes, resetting to 10 degrees.
// - the local and remote start/span registers reset to 0x41 and 0x61 and are read/write.
// - with the alarm-forces-full-fan bit set (reset 1), own alarm assertion forces full fan.
// - with that bit clear, own alarm assertion leaves the fan under normal control.
// - an alarm pin pulled low from outside forces full fan regardless of the bit.
// - alarm register bits 6:4 are read-only zeros and ignore writes.
// - alarm register bits 3:0 return a fixed read-only revision and ignore writes.
// - local offset bit 7 chooses add (0) or subtract (1); the register resets to 0x00.
// - local offset bits 6:4 are writable but unused and read back as zeros.
// - in automatic mode the normal-speed nibble is the minimum fan speed.
// - the local offset magnitude is bits 3:0, up to 15 degrees.
package fan_loop_pkg;
  localparam logic [7:0] LOCAL_OFFSET_ADDR = 8'h0d;
  localparam logic [7:0] LOCAL_START_SPAN_ADDR = 8'h24;
  localparam logic [7:0] REMOTE_START_SPAN_ADDR = 8'h25;
  localparam logic [7:0] ALARM_REV_ADDR = 8'h3f;
  localparam logic [7:0] LOCAL_OFFSET_RESET = 8'h00;
  localparam logic [7:0] LOCAL_START_SPAN_RESET = 8'h41;
  localparam logic [7:0] REMOTE_START_SPAN_RESET = 8'h61;
  localparam logic ALARM_FULL_RESET = 1'b1;
  // revision value is arbitrary
  localparam logic [3:0] REVISION = 4'h1;
  localparam logic [3:0] FULL_SPEED = 4'hf;
  localparam int START_LSB = 3;
  localparam int START_STEP_SHIFT = 2;
  localparam int SIGN_BIT = 7;
  localparam int ALARM_FULL_BIT = 7;

  typedef struct packed {
    logic [4:0] start;
    logic [2:0] span;
  } start_span_s;

  typedef struct packed {
    logic [7:0] temp;
    logic alarm_own;
    logic alarm_ext;
    logic auto_mode;
    logic [3:0] min_speed;
  } fan_inputs_s;
endpackage

// ===== core/fan_loop_config_regs.sv
// fan loop configuration register bank and automatic speed computation
// assumes a decoded byte-wide register port from the management bus slave
`timescale 1ns/1ps
module fan_loop_config_regs
  import fan_loop_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] local_temp_i,
  input wire logic [7:0] remote_temp_i,
  input wire logic alarm_own_i,
  input wire logic alarm_pin_low_i,
  input wire logic auto_mode_i,
  input wire logic [3:0] min_speed_i,
  output logic [7:0] local_temp_adj_o,
  output logic [3:0] fan_speed_o,
  output logic [4:0] local_start_o,
  output logic [4:0] remote_start_o
);
  logic [1:0] rst_sync;
  logic [1:0] next_rst_sync;
  logic rst_n;
  logic [1:0] ext_sync;
  logic [1:0] next_ext_sync;
  start_span_s local_ss, next_local_ss;
  start_span_s remote_ss, next_remote_ss;
  logic alarm_full, next_alarm_full;
  logic [7:0] offset, next_offset;
  logic [7:0] next_rdata;
  logic [7:0] next_adj;
  logic [3:0] next_speed;
  logic wr_local, wr_remote, wr_alarm, wr_offset;
  start_span_s chan_ss [2];
  logic [7:0] chan_temp [2];
  logic [3:0] chan_spd [2];
  fan_inputs_s fan_in;

  // reset release: ones shift in once the pin goes high
  always_comb begin
    next_rst_sync = {rst_sync[0], 1'h1};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= next_rst_sync;
    end
  end
  assign rst_n = rst_sync[1];

  // external alarm pin is asynchronous
  always_comb begin
    next_ext_sync = {ext_sync[0], alarm_pin_low_i};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync <= 2'h0;
    end else begin
      ext_sync <= next_ext_sync;
    end
  end

  // span code to degrees: 5 shifted left by the code
  function automatic logic [8:0] span_deg(input logic [2:0] code);
    span_deg = 9'h005 << code;
  endfunction

  // speed ramp for one channel
  function automatic logic [3:0] ramp(input logic [7:0] temp,
                                      input start_span_s ss,
                                      input logic [3:0] min_spd);
    logic [8:0] start_deg;
    logic [8:0] span;
    logic [8:0] above;
    logic [12:0] prod;
    logic [12:0] step;
    start_deg = {2'h0, ss.start, 2'h0};
    span = span_deg(ss.span);
    above = 9'h000;
    prod = 13'h0000;
    step = 13'h0000;
    if ({1'h0, temp} < start_deg) begin
      ramp = 4'h0;
    end else if ({1'h0, temp} >= start_deg + span) begin
      ramp = FULL_SPEED;
    end else begin
      above = {1'h0, temp} - start_deg;
      prod = 13'(above) * 13'(FULL_SPEED - min_spd);
      step = prod / 13'(span);
      ramp = min_spd + step[3:0];
    end
  endfunction

  // write strobes per register
  always_comb begin
    wr_local = reg_wr_i && (reg_addr_i == LOCAL_START_SPAN_ADDR);
    wr_remote = reg_wr_i && (reg_addr_i == REMOTE_START_SPAN_ADDR);
    wr_alarm = reg_wr_i && (reg_addr_i == ALARM_REV_ADDR);
    wr_offset = reg_wr_i && (reg_addr_i == LOCAL_OFFSET_ADDR);
  end

  // next register values; unmapped addresses are ignored
  always_comb begin
    next_local_ss = local_ss;
    next_remote_ss = remote_ss;
    next_alarm_full = alarm_full;
    next_offset = offset;
    if (wr_local) begin
      next_local_ss = reg_wdata_i;
    end
    if (wr_remote) begin
      next_remote_ss = reg_wdata_i;
    end
    if (wr_alarm) begin
      next_alarm_full = reg_wdata_i[ALARM_FULL_BIT];
    end
    if (wr_offset) begin
      next_offset = reg_wdata_i;
    end
  end

  // read mux, registered one cycle after the address
  always_comb begin
    case (reg_addr_i)
      LOCAL_START_SPAN_ADDR: next_rdata = local_ss;
      REMOTE_START_SPAN_ADDR: next_rdata = remote_ss;
      ALARM_REV_ADDR: next_rdata = {alarm_full, 3'h0, REVISION};
      LOCAL_OFFSET_ADDR: next_rdata = {offset[7], 3'h0, offset[3:0]};
      default: next_rdata = 8'h00;
    endcase
  end

  // carrier of what the speed decision depends on
  always_comb begin
    fan_in = '0;
    fan_in.temp = next_adj;
    fan_in.alarm_own = alarm_own_i;
    fan_in.alarm_ext = ext_sync[1];
    fan_in.auto_mode = auto_mode_i;
    fan_in.min_speed = min_speed_i;
  end

  // signed-magnitude local offset
  always_comb begin
    if (offset[SIGN_BIT]) begin
      next_adj = local_temp_i - {4'h0, offset[3:0]};
    end else begin
      next_adj = local_temp_i + {4'h0, offset[3:0]};
    end
  end

  assign chan_ss[0] = local_ss;
  assign chan_ss[1] = remote_ss;
  assign chan_temp[0] = fan_in.temp;
  assign chan_temp[1] = remote_temp_i;

  // one speed ramp per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      assign chan_spd[ch] = ramp(chan_temp[ch], chan_ss[ch],
                                 fan_in.min_speed);
    end
  endgenerate

  // alarms first, then the automatic ramp or the fixed speed
  always_comb begin
    next_speed = fan_in.min_speed;
    if (fan_in.alarm_ext) begin
      next_speed = FULL_SPEED;
    end else if (fan_in.alarm_own && alarm_full) begin
      next_speed = FULL_SPEED;
    end else if (fan_in.auto_mode) begin
      next_speed = chan_spd[1];
      if (chan_spd[0] > chan_spd[1]) begin
        next_speed = chan_spd[0];
      end
      if (next_speed < fan_in.min_speed) begin
        next_speed = fan_in.min_speed;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      local_ss <= LOCAL_START_SPAN_RESET;
      remote_ss <= REMOTE_START_SPAN_RESET;
      alarm_full <= ALARM_FULL_RESET;
      offset <= LOCAL_OFFSET_RESET;
    end else begin
      local_ss <= next_local_ss;
      remote_ss <= next_remote_ss;
      alarm_full <= next_alarm_full;
      offset <= next_offset;
    end
  end

  // read data
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // speed and adjusted temperature
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      local_temp_adj_o <= 8'h00;
      fan_speed_o <= 4'h0;
    end else begin
      local_temp_adj_o <= fan_in.temp;
      fan_speed_o <= next_speed;
    end
  end

  assign local_start_o = local_ss.start;
  assign remote_start_o = remote_ss.start;
endmodule

// ===== test/fan_loop_config_regs_asserts.sv
// port assertions for the fan loop register bank
// assumes one clock domain; bound to the top module
`timescale 1ns/1ps
module fan_loop_config_regs_asserts
  import fan_loop_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic alarm_own_i,
  input wire logic alarm_pin_low_i,
  input wire logic [3:0] fan_speed_o,
  input wire logic [4:0] local_start_o,
  input wire logic [4:0] remote_start_o
);
  logic [1:0] up;
  logic [1:0] next_up;
  logic ok;
  assign ok = (up == 2'h3);
  always_comb next_up = ok ? up : up + 2'h1;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up <= 2'h0;
    end else begin
      up <= next_up;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr_loc;
    ok && reg_wr_i && reg_addr_i == LOCAL_START_SPAN_ADDR
    ##1 reg_addr_i == LOCAL_START_SPAN_ADDR && !reg_wr_i;
  endsequence
  a_alarm_rsvd_zero: assert property (ok && reg_addr_i == ALARM_REV_ADDR
    |=> reg_rdata_o[6:4] == 3'h0) else $error("alarm pad bits set");
  a_rev_fixed: assert property (ok && reg_addr_i == ALARM_REV_ADDR
    |=> reg_rdata_o[3:0] == REVISION) else $error("revision wrong");
  a_offset_pad_zero: assert property (ok && reg_addr_i == LOCAL_OFFSET_ADDR
    |=> reg_rdata_o[6:4] == 3'h0) else $error("offset pad bits set");
  a_local_start_out: assert property (ok && reg_addr_i == LOCAL_START_SPAN_ADDR
    |=> reg_rdata_o[7:3] == $past(local_start_o)) else $error("local start");
  a_remote_start_out: assert property (ok && reg_addr_i == REMOTE_START_SPAN_ADDR
    |=> reg_rdata_o[7:3] == $past(remote_start_o)) else $error("remote start");
  a_write_read_back: assert property (s_wr_loc |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("write lost");
  a_ext_alarm_full: assert property (ok && alarm_pin_low_i [*3] |=>
    fan_speed_o == FULL_SPEED) else $error("ext alarm not full");
  a_own_alarm_full: assert property (ok && alarm_own_i && reg_rdata_o[7]
    && $past(reg_addr_i) == ALARM_REV_ADDR && !reg_wr_i && !$past(reg_wr_i)
    |=> fan_speed_o == FULL_SPEED) else $error("own alarm not full");
endmodule
bind fan_loop_config_regs fan_loop_config_regs_asserts u_chk (.*);

// ===== test/test_fan_loop_config_regs.sv
// self-checking bench for the fan loop register bank
// assumes the package and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_fan_loop_config_regs
  import fan_loop_pkg::*;
;
  logic clk_i = 0, resetn_i = 0, reg_wr_i = 0, alarm_own_i = 0, ma = 1;
  logic alarm_pin_low_i = 0, auto_mode_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, t, al[5];
  logic [7:0] local_temp_i = 0, remote_temp_i = 0, local_temp_adj_o;
  logic [7:0] mo = 8'h00, ml = 8'h41, mr = 8'h61;
  logic [3:0] min_speed_i = 0, fan_speed_o;
  logic [4:0] local_start_o, remote_start_o;
  logic [7:0] u;
  logic [3:0] m;
  int fail_count = 0, compares = 0, cyc = 0, ev;
  fan_loop_config_regs u_dut (.*);
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      fail_count++;
      summarize();
    end
  end
  function automatic logic [7:0] ex(input logic [7:0] a);
    case (a)
      LOCAL_OFFSET_ADDR: return {mo[7], 3'h0, mo[3:0]};
      LOCAL_START_SPAN_ADDR: return ml;
      REMOTE_START_SPAN_ADDR: return mr;
      ALARM_REV_ADDR: return {ma, 3'h0, REVISION};
      default: return 8'h00;
    endcase
  endfunction
  function automatic int ramp_m(input int tmp, input logic [7:0] ss,
                                input int mn);
    int st;
    int sp;
    st = ss[7:3] * 4;
    sp = 5 << ss[2:0];
    if (tmp < st) return 0;
    if (tmp >= st + sp) return FULL_SPEED;
    return mn + (tmp - st) * (FULL_SPEED - mn) / sp;
  endfunction
  task automatic wr(input logic [7:0] a, w);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wr_i <= 1'b1;
    reg_wdata_i <= w;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    if (a == LOCAL_OFFSET_ADDR) mo = w;
    if (a == LOCAL_START_SPAN_ADDR) ml = w;
    if (a == REMOTE_START_SPAN_ADDR) mr = w;
    if (a == ALARM_REV_ADDR) ma = w[7];
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("rdata", ex(a), reg_rdata_o)
  endtask
  task automatic hold(input int n, input logic [3:0] e);
    repeat (n) @(posedge clk_i);
    #1;
    `CHK("speed", e, fan_speed_o)
    @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    al = '{LOCAL_OFFSET_ADDR, LOCAL_START_SPAN_ADDR, REMOTE_START_SPAN_ADDR,
      ALARM_REV_ADDR, 8'h3e};
    t = 8'($urandom(32'h4c23));
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (al[i]) rd(al[i]);
    repeat (4) foreach (al[i]) begin
      wr(al[i], 8'($urandom));
      rd(al[i]);
    end
    repeat (6) begin
      wr(LOCAL_OFFSET_ADDR, 8'($urandom));
      t = 8'($urandom);
      local_temp_i <= t;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK("adj", mo[7] ? t - mo[3:0] : t + mo[3:0], local_temp_adj_o)
    end
    wr(ALARM_REV_ADDR, 8'h00);
    m = 4'($urandom);
    min_speed_i <= m;
    alarm_own_i <= 1'b1;
    hold(3, m);
    alarm_pin_low_i <= 1'b1;
    hold(5, FULL_SPEED);
    alarm_pin_low_i <= 1'b0;
    wr(ALARM_REV_ADDR, 8'h80);
    hold(2, FULL_SPEED);
    wr(LOCAL_OFFSET_ADDR, 8'h00);
    alarm_own_i <= 1'b0;
    auto_mode_i <= 1'b1;
    local_temp_i <= 8'h00;
    hold(5, min_speed_i);
    repeat (8) begin
      wr(LOCAL_START_SPAN_ADDR, {5'($urandom), 3'($urandom % 5)});
      wr(REMOTE_START_SPAN_ADDR, {5'($urandom), 3'($urandom % 5)});
      t = 8'(ml[7:3] * 4 + $urandom % 96);
      u = 8'(mr[7:3] * 4 + $urandom % 96);
      m = 4'($urandom);
      local_temp_i <= t;
      remote_temp_i <= u;
      min_speed_i <= m;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK("lstart", ml[7:3], local_start_o)
      `CHK("rstart", mr[7:3], remote_start_o)
      ev = ramp_m(t, ml, m);
      if (ramp_m(u, mr, m) > ev) ev = ramp_m(u, mr, m);
      if (ev < m) ev = m;
      `CHK("auto", ev, fan_speed_o)
    end
    summarize();
  end
endmodule
